// >>> byte_serializer.sv
`timescale 1ns/100ps
`default_nettype none

module byte_serializer (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // load side, taken only while empty
   input wire logic load,
   input wire logic [63:0] load_bytes,
   input wire logic [3:0] load_count,
   input wire logic load_last,
   output logic empty,
   // byte stream side
   output logic [7:0] out_data,
   output logic out_valid,
   output logic out_last,
   input wire logic out_ready
);

   typedef struct packed {
      logic [63:0] bytes; // byte 0 sits in the low lane
      logic [3:0] left;   // bytes still to send
      logic last;         // final byte closes the payload
   } ser_state_type;

   ser_state_type s_q, s_d;

   ////////////////////////////////////////////////////////////////////////
   // shift one byte per beat, low first
   always_comb begin
      s_d = s_q;
      if (s_q.left == 4'h0) begin
         if (load) begin
            s_d.bytes = load_bytes;
            s_d.left = load_count;
            s_d.last = load_last;
         end
      end else if (out_ready) begin
         s_d.bytes = {8'h00, s_q.bytes[63:8]};
         s_d.left = s_q.left - 4'h1;
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign empty = (s_q.left == 4'h0);
   assign out_valid = (s_q.left != 4'h0);
   assign out_data = s_q.bytes[7:0];
   assign out_last = s_q.last && (s_q.left == 4'h1);

endmodule : byte_serializer

`default_nettype wire

// >>> epf_chk.sv
`timescale 1ns/100ps
`default_nettype none

module epf_chk (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // bus handshake
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   // payload stream
   input wire logic [7:0] EVT_DATA,
   input wire logic EVT_VALID,
   input wire logic EVT_LAST,
   input wire logic [1:0] EVT_CLASS,
   input wire logic EVT_READY,
   // poll request
   input wire logic POLL_REQ_VALID,
   input wire logic POLL_REQ_ACK_ONLY,
   input wire logic [31:0] POLL_REQ_HANDLE,
   input wire logic [31:0] POLL_HANDLE_USED
);
   import event_formatter_pkg::*;

   logic [16:0] cnt_q; // byte index inside the payload
   logic [7:0] prev_q; // byte taken before this one
   logic [15:0] len_q; // error byte count once seen
   logic [15:0] len_w; // count valid from its high byte on
   // zero count ends on the high byte
   assign len_w = (cnt_q == 17'd3) ? {EVT_DATA, prev_q} : len_q;

   // byte index and low halves
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cnt_q <= 17'h0;
         prev_q <= 8'h0;
         len_q <= 16'h0;
      end else if (EVT_VALID && EVT_READY) begin
         cnt_q <= EVT_LAST ? 17'h0 : cnt_q + 17'h1;
         prev_q <= EVT_DATA;
         len_q <= len_w;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence s_take;
      EVT_VALID && EVT_READY;
   endsequence

   property p_rev;
      $rose(EVT_VALID) && $past(EVT_CLASS) == CLASS_NONE |-> EVT_DATA == PAYLOAD_REVISION;
   endproperty
   a_rev: assert property (p_rev) else $error("no revision");
   property p_hold;
      EVT_VALID && !EVT_READY |=> EVT_VALID && $stable(EVT_DATA) && $stable(EVT_LAST);
   endproperty
   a_hold: assert property (p_hold) else $error("byte moved on stall");
   property p_tag;
      s_take ##0 (EVT_CLASS == CLASS_POLL_NOTICE && cnt_q == 17'd2)
         |-> {EVT_DATA, prev_q} inside {[TAG_LOWEST:TAG_HIGHEST]};
   endproperty
   a_tag: assert property (p_tag) else $error("reserved tag");
   property p_poll_len;
      s_take ##0 (EVT_LAST && EVT_CLASS == CLASS_POLL_NOTICE) |-> cnt_q == 17'd6;
   endproperty
   a_poll_len: assert property (p_poll_len) else $error("poll length");
   property p_beat;
      s_take ##0 (EVT_CLASS == CLASS_KEEPALIVE && cnt_q == 17'd0)
         |=> EVT_VALID && EVT_LAST && EVT_CLASS == CLASS_KEEPALIVE;
   endproperty
   a_beat: assert property (p_beat) else $error("beat length");
   property p_form;
      s_take ##0 (EVT_CLASS == CLASS_PLATFORM_ERROR && cnt_q == 17'd1)
         |-> EVT_DATA <= FORM_ONE_SECTION;
   endproperty
   a_form: assert property (p_form) else $error("reserved form");
   property p_err_len;
      s_take ##0 (EVT_LAST && EVT_CLASS == CLASS_PLATFORM_ERROR)
         |-> cnt_q == {1'b0, len_w} + 17'd3;
   endproperty
   a_err_len: assert property (p_err_len) else $error("error length");
   property p_ack;
      CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a pulse");
   property p_handle;
      POLL_REQ_VALID |=> POLL_HANDLE_USED
         == ($past(POLL_REQ_ACK_ONLY) ? 32'h0 : $past(POLL_REQ_HANDLE));
   endproperty
   a_handle: assert property (p_handle) else $error("handle used wrong");
endmodule : epf_chk

`default_nettype wire

// >>> event_formatter_pkg.sv
package event_formatter_pkg;

   // payload constants
   localparam logic [7:0] PAYLOAD_REVISION = 8'h01;
   localparam logic [15:0] TAG_LOWEST = 16'h0001;
   localparam logic [15:0] TAG_HIGHEST = 16'hfffe;
   localparam logic [7:0] FORM_FULL_RECORD = 8'h00;
   localparam logic [7:0] FORM_ONE_SECTION = 8'h01;

   // header lengths in bytes
   localparam logic [3:0] KEEPALIVE_HDR_BYTES = 4'h2;
   localparam logic [3:0] POLL_HDR_BYTES = 4'h7;
   localparam logic [3:0] ERROR_HDR_BYTES = 4'h4;

   // receiver global enable encodings
   localparam logic [1:0] GLOBAL_DISABLE = 2'h0;
   localparam logic [1:0] GLOBAL_ASYNC = 2'h1;
   localparam logic [1:0] GLOBAL_POLLING = 2'h2;
   localparam logic [1:0] ASYNC_KEEPALIVE_OPTION = 2'h3;

   // event class codes on the output stream
   localparam logic [1:0] CLASS_NONE = 2'h0;
   localparam logic [1:0] CLASS_POLL_NOTICE = 2'h1;
   localparam logic [1:0] CLASS_KEEPALIVE = 2'h2;
   localparam logic [1:0] CLASS_PLATFORM_ERROR = 2'h3;

   // register byte offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_HB_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_POLL_TAG = 8'h08;
   localparam logic [7:0] ADDR_POLL_HANDLE = 8'h0c;
   localparam logic [7:0] ADDR_ERROR_HDR = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
   localparam logic [7:0] ADDR_HANDLE_USED = 8'h20;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_START_POLL = 4;
   localparam int CTRL_START_ERROR = 5;
   // error header register fields
   localparam int ERRH_FORM_LSB = 0;
   localparam int ERRH_COUNT_LSB = 16;
   // status register fields
   localparam int STAT_COUNTER_LSB = 0;
   localparam int STAT_BUSY = 8;
   localparam int STAT_HB_PEND = 9;
   localparam int STAT_POLL_PEND = 10;
   localparam int STAT_ERR_PEND = 11;

   // interrupt status bits
   localparam int IRQ_KEEPALIVE_SENT = 0;
   localparam int IRQ_POLL_SENT = 1;
   localparam int IRQ_ERROR_SENT = 2;
   localparam int IRQ_BAD_TAG = 3;
   localparam int IRQ_BAD_FORM = 4;
   localparam int IRQ_POLL_REQ = 5;
   localparam int IRQ_BITS = 6;

   // reset values
   localparam logic [1:0] MODE_RESET = GLOBAL_DISABLE;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

   // heartbeat period default: time and derived cycle count
   localparam int CLOCK_MHZ = 125;
   localparam int HB_PERIOD_US = 1000;
   localparam int HB_PERIOD_CYCLES = HB_PERIOD_US * CLOCK_MHZ;

endpackage : event_formatter_pkg

// >>> event_payload_formatter.sv
//
// Contract
// - every payload opens with revision byte 0x01
// - poll tag only 0x0001 through 0xfffe
// - poll carries 32-bit handle, zero allowed
// - ack-only poll request ignores supplied handle
// - heartbeat sent each time timer elapses; a beat still unsent at the next elapse is replaced, not sent twice; an elapse as a waiting beat loads sends none
// - heartbeat only under async keep-alive option
// - counter follows revision, +1 per elapse
// - error form code follows revision, 0x02+ reserved
// - 16-bit exact byte count follows form code
// - form 0x00 data holds full record chunk
// - form 0x01 holds one section
`timescale 1ns/100ps
`default_nettype none

module event_payload_formatter #(
   parameter int HB_DEFAULT_CYCLES = event_formatter_pkg::HB_PERIOD_CYCLES
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET,
   // wishbone classic slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // interrupt
   output logic IRQ,
   // payload byte stream out
   output logic [7:0] EVT_DATA,
   output logic EVT_VALID,
   output logic EVT_LAST,
   output logic [1:0] EVT_CLASS,
   input wire logic EVT_READY,
   // record body bytes in
   input wire logic [7:0] ERR_DATA,
   input wire logic ERR_VALID,
   output logic ERR_READY,
   // decoded poll request
   input wire logic POLL_REQ_VALID,
   input wire logic POLL_REQ_ACK_ONLY,
   input wire logic [31:0] POLL_REQ_HANDLE,
   output logic [31:0] POLL_HANDLE_USED
);
   import event_formatter_pkg::*;

   // framer states
   typedef enum logic [1:0] {
      FRAME_IDLE = 2'b00,
      FRAME_DRAIN = 2'b01,
      FRAME_BODY = 2'b10
   } frame_type;

   typedef struct packed {
      // software registers
      logic [1:0] receiver_global_enable;
      logic [31:0] hb_period;
      logic [15:0] multipart_event_tag;
      logic [31:0] fetch_handle;
      logic [7:0] error_record_form_code;
      logic [15:0] error_data_byte_count;
      logic [IRQ_BITS-1:0] irq_status;
      logic [IRQ_BITS-1:0] irq_mask;
      logic [31:0] handle_used;
      // keep-alive state
      logic [7:0] heartbeat_counter;
      // pending events
      logic hb_pend;
      logic poll_pend;
      logic err_pend;
      // framer
      frame_type frame;
      logic [1:0] evt_class;
      logic [15:0] body_left;
      // bus answer
      logic ack;
      logic [31:0] rdata;
   } top_state_type;

   top_state_type s_q, s_d;

   // sub-block wires
   logic hb_tick; // timer elapse pulse
   logic ser_load; // load strobe into the serializer
   logic [63:0] ser_bytes; // bytes to load, low lane first
   logic [3:0] ser_count; // number of bytes loaded
   logic ser_last; // load closes the payload
   logic ser_empty; // serializer can take a load
   logic keepalive_on; // option selected
   logic bus_req; // new bus request this cycle
   logic bus_wr; // new bus write this cycle
   logic [31:0] wmask; // byte lane mask from select

   ////////////////////////////////////////////////////////////////////////
   // sub-blocks

   assign keepalive_on = (s_q.receiver_global_enable == ASYNC_KEEPALIVE_OPTION);

   // timer idles outside the keep-alive option
   heartbeat_timer timer_inst (
      .clock(CLOCK),
      .reset(RESET),
      .enable(keepalive_on),
      .period(s_q.hb_period),
      .tick(hb_tick)
   );

   byte_serializer ser_inst (
      .clock(CLOCK),
      .reset(RESET),
      .load(ser_load),
      .load_bytes(ser_bytes),
      .load_count(ser_count),
      .load_last(ser_last),
      .empty(ser_empty),
      .out_data(EVT_DATA),
      .out_valid(EVT_VALID),
      .out_last(EVT_LAST),
      .out_ready(EVT_READY)
   );

   ////////////////////////////////////////////////////////////////////////
   // bus decode helpers

   // ack gap keeps a held request single
   assign bus_req = CYC_I && STB_I && !s_q.ack;
   assign bus_wr = bus_req && WE_I;

   // byte lanes follow the select lines
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{SEL_I[i]}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state for registers, events and framer
   always_comb begin
      logic [IRQ_BITS-1:0] irq_set; // events seen this cycle
      logic [31:0] ctrl_w; // masked control write
      irq_set = '0;
      ctrl_w = 32'h0;
      s_d = s_q;
      ser_load = 1'b0;
      ser_bytes = 64'h0;
      ser_count = 4'h0;
      ser_last = 1'b0;
      ERR_READY = 1'b0;

      // answer one cycle later
      s_d.ack = bus_req;
      s_d.rdata = 32'h0;

      // register writes
      if (bus_wr) begin
         unique case (ADR_I)
            ADDR_CONTROL: begin
               ctrl_w = DAT_I & wmask;
               if (SEL_I[0]) begin
                  s_d.receiver_global_enable = DAT_I[CTRL_MODE_LSB +: 2];
               end
               // starts ignored while one is pending
               if (ctrl_w[CTRL_START_POLL] && !s_q.poll_pend) begin
                  // reserved tags refused
                  if (s_q.multipart_event_tag >= TAG_LOWEST &&
                      s_q.multipart_event_tag <= TAG_HIGHEST) begin
                     s_d.poll_pend = 1'b1;
                  end else begin
                     irq_set[IRQ_BAD_TAG] = 1'b1;
                  end
               end
               if (ctrl_w[CTRL_START_ERROR] && !s_q.err_pend) begin
                  // only defined forms go out
                  if (s_q.error_record_form_code == FORM_FULL_RECORD ||
                      s_q.error_record_form_code == FORM_ONE_SECTION) begin
                     s_d.err_pend = 1'b1;
                  end else begin
                     irq_set[IRQ_BAD_FORM] = 1'b1;
                  end
               end
            end
            ADDR_HB_PERIOD: begin
               s_d.hb_period = (s_q.hb_period & ~wmask) | (DAT_I & wmask);
            end
            ADDR_POLL_TAG: begin
               s_d.multipart_event_tag = (s_q.multipart_event_tag & ~wmask[15:0]) |
                                         (DAT_I[15:0] & wmask[15:0]);
            end
            ADDR_POLL_HANDLE: begin
               // zero handle legal
               s_d.fetch_handle = (s_q.fetch_handle & ~wmask) | (DAT_I & wmask);
            end
            ADDR_ERROR_HDR: begin
               s_d.error_record_form_code = (s_q.error_record_form_code & ~wmask[7:0]) |
                                            (DAT_I[7:0] & wmask[7:0]);
               s_d.error_data_byte_count = (s_q.error_data_byte_count & ~wmask[31:16]) |
                                           (DAT_I[31:16] & wmask[31:16]);
            end
            ADDR_IRQ_MASK: begin
               s_d.irq_mask = (s_q.irq_mask & ~wmask[IRQ_BITS-1:0]) |
                              (DAT_I[IRQ_BITS-1:0] & wmask[IRQ_BITS-1:0]);
            end
            default: begin
               // acked, no effect here; irq status w1c handled below
            end
         endcase
      end

      // reads, unmapped read zero
      if (bus_req && !WE_I) begin
         unique case (ADR_I)
            ADDR_CONTROL: s_d.rdata[CTRL_MODE_LSB +: 2] = s_q.receiver_global_enable;
            ADDR_HB_PERIOD: s_d.rdata = s_q.hb_period;
            ADDR_POLL_TAG: s_d.rdata[15:0] = s_q.multipart_event_tag;
            ADDR_POLL_HANDLE: s_d.rdata = s_q.fetch_handle;
            ADDR_ERROR_HDR: begin
               s_d.rdata[ERRH_FORM_LSB +: 8] = s_q.error_record_form_code;
               s_d.rdata[ERRH_COUNT_LSB +: 16] = s_q.error_data_byte_count;
            end
            ADDR_STATUS: begin
               s_d.rdata[STAT_COUNTER_LSB +: 8] = s_q.heartbeat_counter;
               s_d.rdata[STAT_BUSY] = (s_q.frame != FRAME_IDLE) || !ser_empty;
               s_d.rdata[STAT_HB_PEND] = s_q.hb_pend;
               s_d.rdata[STAT_POLL_PEND] = s_q.poll_pend;
               s_d.rdata[STAT_ERR_PEND] = s_q.err_pend;
            end
            ADDR_IRQ_STATUS: s_d.rdata[IRQ_BITS-1:0] = s_q.irq_status;
            ADDR_IRQ_MASK: s_d.rdata[IRQ_BITS-1:0] = s_q.irq_mask;
            ADDR_HANDLE_USED: s_d.rdata = s_q.handle_used;
            default: s_d.rdata = 32'h0;
         endcase
      end

      // count each elapse, queue a beat
      if (hb_tick) begin
         s_d.heartbeat_counter = s_q.heartbeat_counter + 8'h01;
         // unsent beat replaced, gap shows it
         s_d.hb_pend = 1'b1;
      end
      // option off drops a waiting beat
      if (!keepalive_on) begin
         s_d.hb_pend = 1'b0;
      end

      // poll request in
      if (POLL_REQ_VALID) begin
         // ack-only handle is meaningless
         s_d.handle_used = POLL_REQ_ACK_ONLY ? 32'h0 : POLL_REQ_HANDLE;
         irq_set[IRQ_POLL_REQ] = 1'b1;
      end

      // keep-alive first: short, time-critical
      unique case (s_q.frame)
         FRAME_IDLE: begin
            if (ser_empty) begin
               if (s_q.hb_pend && keepalive_on) begin
                  ser_bytes[15:0] = {s_q.heartbeat_counter, PAYLOAD_REVISION};
                  ser_count = KEEPALIVE_HDR_BYTES;
                  ser_last = 1'b1;
                  ser_load = 1'b1;
                  s_d.hb_pend = 1'b0;
                  s_d.evt_class = CLASS_KEEPALIVE;
                  s_d.frame = FRAME_DRAIN;
                  irq_set[IRQ_KEEPALIVE_SENT] = 1'b1;
               end else if (s_q.poll_pend) begin
                  // low byte first
                  ser_bytes[55:0] = {s_q.fetch_handle, s_q.multipart_event_tag,
                                     PAYLOAD_REVISION};
                  ser_count = POLL_HDR_BYTES;
                  ser_last = 1'b1;
                  ser_load = 1'b1;
                  s_d.poll_pend = 1'b0;
                  s_d.evt_class = CLASS_POLL_NOTICE;
                  s_d.frame = FRAME_DRAIN;
                  irq_set[IRQ_POLL_SENT] = 1'b1;
               end else if (s_q.err_pend) begin
                  // revision, form, count low first
                  ser_bytes[31:0] = {s_q.error_data_byte_count,
                                     s_q.error_record_form_code,
                                     PAYLOAD_REVISION};
                  ser_count = ERROR_HDR_BYTES;
                  ser_last = (s_q.error_data_byte_count == 16'h0000);
                  ser_load = 1'b1;
                  s_d.err_pend = 1'b0;
                  s_d.evt_class = CLASS_PLATFORM_ERROR;
                  s_d.body_left = s_q.error_data_byte_count;
                  s_d.frame = (s_q.error_data_byte_count == 16'h0000) ?
                              FRAME_DRAIN : FRAME_BODY;
               end
            end
         end
         FRAME_BODY: begin
            // bytes pass untouched, count exact;
            // no buffer costs a bubble per byte
            ERR_READY = ser_empty;
            if (ser_empty && ERR_VALID) begin
               ser_bytes[7:0] = ERR_DATA;
               ser_count = 4'h1;
               ser_last = (s_q.body_left == 16'h0001);
               ser_load = 1'b1;
               s_d.body_left = s_q.body_left - 16'h0001;
               if (s_q.body_left == 16'h0001) begin
                  s_d.frame = FRAME_DRAIN;
               end
            end
         end
         FRAME_DRAIN: begin
            // close once the last byte left
            if (ser_empty) begin
               if (s_q.evt_class == CLASS_PLATFORM_ERROR) begin
                  irq_set[IRQ_ERROR_SENT] = 1'b1;
               end
               s_d.evt_class = CLASS_NONE;
               s_d.frame = FRAME_IDLE;
            end
         end
         default: begin
            // spare code to idle
            s_d.frame = FRAME_IDLE;
         end
      endcase

      // w1c status, new event wins
      if (bus_wr && ADR_I == ADDR_IRQ_STATUS) begin
         s_d.irq_status = s_q.irq_status & ~(DAT_I[IRQ_BITS-1:0] & wmask[IRQ_BITS-1:0]);
      end
      s_d.irq_status = s_d.irq_status | irq_set;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         s_q <= '0;
         s_q.receiver_global_enable <= MODE_RESET;
         s_q.hb_period <= 32'(HB_DEFAULT_CYCLES);
         s_q.irq_mask <= IRQ_MASK_RESET;
         s_q.frame <= FRAME_IDLE;
         s_q.evt_class <= CLASS_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign DAT_O = s_q.rdata;
   assign ACK_O = s_q.ack;
   assign IRQ = |(s_q.irq_status & s_q.irq_mask);
   assign EVT_CLASS = s_q.evt_class;
   assign POLL_HANDLE_USED = s_q.handle_used;

endmodule : event_payload_formatter

`default_nettype wire

// >>> heartbeat_timer.sv
`timescale 1ns/100ps
`default_nettype none

module heartbeat_timer (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // control
   input wire logic enable,
   input wire logic [31:0] period,
   // one-cycle elapse pulse
   output logic tick
);

   typedef struct packed {
      logic [31:0] count; // cycles since last elapse
      logic tick;         // elapse pulse
   } timer_state_type;

   timer_state_type s_q, s_d;

   ////////////////////////////////////////////////////////////////////////
   // next state: period zero acts as one
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!enable) begin
         // restart while off
         s_d.count = 32'h0;
      end else if (s_q.count + 32'h1 >= period) begin
         s_d.count = 32'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.count = s_q.count + 32'h1;
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : heartbeat_timer

`default_nettype wire

// >>> sink.sv
`timescale 1ns/100ps
`default_nettype none

module sink (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // bench controls
   input wire logic slow,
   input wire logic ack_only,
   // payload stream in
   input wire logic [7:0] data,
   input wire logic valid,
   input wire logic last,
   input wire logic [1:0] cls,
   output logic ready,
   // poll request out
   output logic req_valid,
   output logic req_ack_only,
   output logic [31:0] req_handle
);
   import event_formatter_pkg::*;

   logic [7:0] got[$]; // bytes received so far
   logic ph_q = 1'b0; // stall phase
   logic [31:0] h_q = 32'h0; // last four bytes, oldest lowest
   // slow: every other cycle, stresses hold
   assign ready = !slow || ph_q;
   // idle bus shows no stale handle
   assign req_handle = req_valid ? h_q : ~h_q;
   initial begin
      req_valid = 1'b0;
      req_ack_only = 1'b0;
   end

   // collect bytes, poll after a notice
   always @(posedge clock) begin
      ph_q <= !ph_q;
      req_valid <= 1'b0;
      if (valid && ready && !reset) begin
         got.push_back(data);
         h_q <= {data, h_q[31:8]};
         if (last && cls == CLASS_POLL_NOTICE) begin
            req_valid <= 1'b1;
            req_ack_only <= ack_only;
         end
      end
   end
endmodule : sink

`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
   import event_formatter_pkg::*;

   logic clock = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0, bi = 8'h0, blen = 8'h0, c;
   logic [31:0] wdat = 32'h0, rdat, q, handle_used, req_handle;
   logic ack, irq, evt_valid, evt_last, evt_ready, err_valid, err_ready;
   logic req_valid, req_ack_only, slow = 1'b0, ack_only = 1'b0;
   logic [7:0] evt_data, err_data;
   logic [1:0] evt_class;
   logic [15:0] tags[3] = '{16'h0001, 16'hfffe, 16'h1234};
   logic [31:0] hdls[3] = '{32'h0, 32'h89abcdef, 32'h01020304};
   int mismatches = 0, n_tests = 0, cycles = 0;

   always #4 clock = ~clock;
   // body source, inverted when idle
   assign err_valid = bi < blen;
   assign err_data = err_valid ? 8'ha0 + bi : ~(8'ha0 + bi);
   always @(posedge clock) if (err_valid && err_ready) bi <= bi + 8'h1;
   // hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end

   event_payload_formatter #(.HB_DEFAULT_CYCLES(20)) event_payload_formatter_inst (
      .CLOCK(clock), .RESET(reset), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .IRQ(irq),
      .EVT_DATA(evt_data), .EVT_VALID(evt_valid), .EVT_LAST(evt_last),
      .EVT_CLASS(evt_class), .EVT_READY(evt_ready), .ERR_DATA(err_data),
      .ERR_VALID(err_valid), .ERR_READY(err_ready), .POLL_REQ_VALID(req_valid),
      .POLL_REQ_ACK_ONLY(req_ack_only), .POLL_REQ_HANDLE(req_handle),
      .POLL_HANDLE_USED(handle_used));
   sink sink_inst (.clock(clock), .reset(reset), .slow(slow), .ack_only(ack_only),
      .data(evt_data), .valid(evt_valid), .last(evt_last), .cls(evt_class),
      .ready(evt_ready), .req_valid(req_valid), .req_ack_only(req_ack_only),
      .req_handle(req_handle));

   ////////////////////////////////////////////////////////////////////
   // one classic cycle, released at the ack edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // wait for a payload, compare bytewise
   task expect_pl(input logic [7:0] e[$]);
      repeat (300) if (sink_inst.got.size() < e.size()) @(posedge clock);
      repeat (4) @(posedge clock);
      chk("byte count", e.size(), sink_inst.got.size());
      foreach (e[i]) chk("payload byte", e[i], sink_inst.got[i]);
      sink_inst.got.delete();
   endtask : expect_pl
   task test_done();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      wb(0, ADDR_IRQ_MASK, 0);
      chk("irq mask", 0, q);
      wb(1, 8'h3c, 32'hffffffff);
      wb(0, 8'h3c, 0);
      chk("unmapped", 0, q);
      wb(1, ADDR_HB_PERIOD, 32'd12);
      for (int m = 0; m < 3; m++) begin
         wb(1, ADDR_CONTROL, m);
         repeat (40) @(posedge clock);
         chk("beats", 0, sink_inst.got.size());
      end
      $display("test modes done");
      wb(0, ADDR_STATUS, 0);
      c = q[7:0];
      slow <= 1'b1;
      wb(1, ADDR_CONTROL, 32'(ASYNC_KEEPALIVE_OPTION));
      repeat (200) if (sink_inst.got.size() < 6) @(posedge clock);
      wb(1, ADDR_CONTROL, 0);
      for (int k = 0; k < 3; k++) begin
         chk("revision", PAYLOAD_REVISION, sink_inst.got[2*k]);
         chk("counter", 8'(c + k + 1), sink_inst.got[2*k+1]);
      end
      repeat (20) @(posedge clock);
      sink_inst.got.delete();
      $display("test keep-alive done");
      wb(1, ADDR_IRQ_MASK, 32'h18);
      foreach (tags[i]) begin
         wb(1, ADDR_POLL_TAG, i == 0 ? 32'h0 : 32'hffff);
         wb(1, ADDR_CONTROL, 32'h10);
         repeat (6) @(posedge clock);
         chk("irq", 1, irq);
         wb(1, ADDR_IRQ_STATUS, 32'h8);
         @(posedge clock);
         chk("irq", 0, irq);
         wb(1, ADDR_POLL_TAG, tags[i]);
         wb(1, ADDR_POLL_HANDLE, hdls[i]);
         ack_only <= i == 1;
         wb(1, ADDR_CONTROL, 32'h10);
         expect_pl('{8'h01, tags[i][7:0], tags[i][15:8], hdls[i][7:0],
            hdls[i][15:8], hdls[i][23:16], hdls[i][31:24]});
         wb(0, ADDR_HANDLE_USED, 0);
         chk("handle used", i == 1 ? 32'h0 : hdls[i], q);
      end
      $display("test poll done");
      wb(1, ADDR_ERROR_HDR, {16'd3, 8'h0, FORM_FULL_RECORD});
      blen <= 8'h3;
      wb(1, ADDR_CONTROL, 32'h20);
      expect_pl('{8'h01, 8'h00, 8'h03, 8'h00, 8'ha0, 8'ha1, 8'ha2});
      wb(1, ADDR_ERROR_HDR, {16'd0, 8'h0, FORM_ONE_SECTION});
      wb(1, ADDR_CONTROL, 32'h20);
      expect_pl('{8'h01, 8'h01, 8'h00, 8'h00});
      wb(1, ADDR_ERROR_HDR, 32'h2);
      wb(1, ADDR_CONTROL, 32'h20);
      expect_pl('{});
      chk("irq", 1, irq);
      $display("test error done");
      test_done();
   end
endmodule : tb

bind event_payload_formatter epf_chk epf_chk_inst (.CLOCK(CLOCK), .RESET(RESET),
   .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .EVT_DATA(EVT_DATA),
   .EVT_VALID(EVT_VALID), .EVT_LAST(EVT_LAST), .EVT_CLASS(EVT_CLASS),
   .EVT_READY(EVT_READY), .POLL_REQ_VALID(POLL_REQ_VALID),
   .POLL_REQ_ACK_ONLY(POLL_REQ_ACK_ONLY), .POLL_REQ_HANDLE(POLL_REQ_HANDLE),
   .POLL_HANDLE_USED(POLL_HANDLE_USED));

`default_nettype wire
